/* rtl/asdsel_debounce.sv */
// synchroniser and programmable debounce for the input comparator
`include "asdsel_defs.svh"
module asdsel_debounce #(
    parameter int CNT_W = 16                      // debounce counter width
) (
    input  wire logic             sys_clk,        // clock
    input  wire logic             srst,           // sync reset
    input  wire logic             ce,             // clock enable
    input  wire logic             comp_async,     // raw comparator level
    input  wire logic [CNT_W-1:0] debounce_limit, // stable cycles needed
    output logic                  level           // debounced level
);

    // ==========================================================
    // synchroniser: first stage feeds only the second
    logic             sync1_reg;
    logic             sync2_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic             level_reg;

    wire logic             differs  = (sync2_reg != level_reg);
    wire logic             reached  = (cnt_reg >= debounce_limit);
    wire logic [CNT_W-1:0] cnt_next =
        differs ? (reached ? '0 : cnt_reg + 1'b1) : '0;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            cnt_reg   <= '0;
            level_reg <= 1'b0;
        end else if (ce) begin
            sync1_reg <= comp_async;
            sync2_reg <= sync1_reg;
            cnt_reg   <= cnt_next;
            // a glitch shorter than the limit restarts the count
            if (differs && reached) begin
                level_reg <= sync2_reg;                      // RULE_06
            end
        end
    end

    assign level = level_reg;

    // ==========================================================
    // checks
    a_deb_no_early: assert property (@(posedge sys_clk) disable iff (srst)
        (ce && differs && !reached) |=> $stable(level_reg)) // RULE_06
        else $error("debounced level moved before limit");

endmodule : asdsel_debounce

/* rtl/asdsel_defs.svh */
// constants of the alert status and diagnostic select register bank
// Behaviour
// RULE_01: codes 0000-0110 pick ground, temperature, supplies, reference
// RULE_02: codes 0111-1101 pick rails, inputs, senses; 1110 ground
// RULE_03: slot 0 code 1111 measures external sink current
// RULE_04: slot 1 code 1111 measures external source current
// RULE_05: level register at 0x40, bit 0, resets zero
// RULE_06: compared input level passes programmable debounce first
// RULE_07: alert flags stay latched, cleared by writing one
// RULE_08: bit 14 latches analog open circuit
// RULE_09: bit 13 latches analog short circuit
// RULE_10: bits 12, 11 timeout latch, output disabled
// RULE_11: bits 10, 9 short, masked in tolerance period
// RULE_12: a flag records internal output thermal reset
// RULE_13: bits 7, 6 latch input open, short errors
// RULE_14: bit 5 latches converter error or saturation
// RULE_15: bit 4 latches die temperature at 115 C
// RULE_16: bit 3 latches power link busy or ack fault
// RULE_17: bit 2 latches serial clock count or CRC error
// RULE_18: supply bit follows any unmasked supply alert
// RULE_19: bit 0 resets one, latches reset event, unmasked
// RULE_20: writing zero, reserved or read-only bits changes nothing
// RULE_21: set beats clear in the same cycle
`ifndef ASDSEL_DEFS_SVH
`define ASDSEL_DEFS_SVH

// ==========================================================
// register map
`define ASD_ADDR_W          8
`define ASD_DATA_W          16
`define ASD_OFS_DIAG_SEL    8'h3C
`define ASD_OFS_DIN_LEVEL   8'h40
`define ASD_OFS_ALERT       8'h41
`define ASD_RST_DIAG_SEL    16'h0000
`define ASD_RST_DIN_LEVEL   16'h0000
`define ASD_RST_ALERT       16'h0001
`define ASD_ALERT_W1C_MASK  16'h7FFD

// ==========================================================
// alert flag positions
`define ASD_BIT_AN_OPEN     14
`define ASD_BIT_AN_SHORT    13
`define ASD_BIT_INT_TMO     12
`define ASD_BIT_EXT_TMO     11
`define ASD_BIT_INT_SHORT   10
`define ASD_BIT_EXT_SHORT   9
`define ASD_BIT_THERMAL     8
`define ASD_BIT_DI_OPEN     7
`define ASD_BIT_DI_SHORT    6
`define ASD_BIT_CONV_ERR    5
`define ASD_BIT_OVER_TEMP   4
`define ASD_BIT_POWER_LINK  3
`define ASD_BIT_SERIAL      2
`define ASD_BIT_SUPPLY      1
`define ASD_BIT_RESET       0

// ==========================================================
// diagnostic slot codes
`define ASD_SLOT_W          4
`define ASD_SRC_COUNT       14
`define ASD_CODE_GND_ALT    4'hE
`define ASD_CODE_CURRENT    4'hF
`define ASD_SRC_GND         0
`define ASD_SLOT0_LSB       0
`define ASD_SLOT1_LSB       4

`endif

/* rtl/asdsel_diag_route.sv */
// decoder from a 4-bit slot source code to a one-hot routing word
`include "asdsel_defs.svh"
module asdsel_diag_route #(
    parameter bit SOURCING = 1'b0                 // 1: code 15 sources
) (
    input  wire logic [`ASD_SLOT_W-1:0] code,     // slot source code
    output asdsel_pkg::asdsel_route_t   route     // decoded routing
);

    // ==========================================================
    // decode
    wire logic is_current = (code == `ASD_CODE_CURRENT);
    wire logic is_gnd_alt = (code == `ASD_CODE_GND_ALT);

    genvar i;
    generate
        for (i = 0; i < `ASD_SRC_COUNT; i++) begin : g_src
            // code order equals source index; 1110 aliases ground
            if (i == `ASD_SRC_GND) begin : g_gnd
                assign route.voltage_sel[i] =
                    (code == `ASD_SLOT_W'(i)) || is_gnd_alt; // RULE_01 RULE_02
            end else begin : g_node
                assign route.voltage_sel[i] =
                    (code == `ASD_SLOT_W'(i));               // RULE_01 RULE_02
            end
        end
    endgenerate

    assign route.current_sink   = is_current && !SOURCING;   // RULE_03
    assign route.current_source = is_current && SOURCING;    // RULE_04

endmodule : asdsel_diag_route

/* rtl/asdsel_pkg.sv */
// types shared by the alert status and diagnostic select block
package asdsel_pkg;

    // ==========================================================
    // alert event inputs, one level per latched flag source
    typedef struct packed {
        logic analog_open;
        logic analog_short;
        logic int_timeout;
        logic ext_timeout;
        logic int_short;
        logic ext_short;
        logic thermal_trip;
        logic di_open;
        logic di_short;
        logic conv_err;
        logic over_temp;
        logic link_busy;
        logic link_ack;
        logic serial_err;
        logic reset_evt;
    } asdsel_evt_t;

    // ==========================================================
    // decoded routing of one diagnostic slot
    typedef struct packed {
        logic [13:0] voltage_sel;
        logic        current_sink;
        logic        current_source;
    } asdsel_route_t;

endpackage : asdsel_pkg

/* rtl/asdsel_top.sv */
// alert status, input level and diagnostic select register bank
`include "asdsel_defs.svh"
module asdsel_top #(
    parameter int SUP_W = 8,                       // supply alert fields
    parameter int DEB_W = 16                       // debounce count width
) (
    input  wire logic                   sys_clk,        // 100 MHz clock
    input  wire logic                   srst,           // sync reset
    input  wire logic                   ce,             // clock enable
    // register port from the serial interface front end
    input  wire logic [`ASD_ADDR_W-1:0] reg_addr,       // register offset
    input  wire logic                   reg_wr,         // write strobe
    input  wire logic                   reg_rd,         // read strobe
    input  wire logic [`ASD_DATA_W-1:0] reg_wdata,      // write data
    output logic      [`ASD_DATA_W-1:0] reg_rdata,      // read data
    // event sources
    input  asdsel_pkg::asdsel_evt_t     evt,            // alert conditions
    input  wire logic                   short_tolerance_period, // start-up
    input  wire logic [SUP_W-1:0]       supply_status,  // supply alerts
    input  wire logic [SUP_W-1:0]       supply_mask,    // 1 masks a field
    // digital input path
    input  wire logic                   comp_async,     // raw comparator
    input  wire logic [DEB_W-1:0]       debounce_limit, // debounce cycles
    // outputs to the analog front end
    output asdsel_pkg::asdsel_route_t   slot0_route,    // slot 0 routing
    output asdsel_pkg::asdsel_route_t   slot1_route,    // slot 1 routing
    output logic                        int_output_disable, // int off
    output logic                        ext_output_disable  // ext off
);

    // ==========================================================
    // state
    logic [`ASD_DATA_W-1:0]    diag_sel_reg;
    logic [`ASD_DATA_W-1:0]    flags_reg;
    logic                      din_level_reg;
    logic [`ASD_DATA_W-1:0]    rdata_reg;
    asdsel_pkg::asdsel_route_t slot0_reg;
    asdsel_pkg::asdsel_route_t slot1_reg;
    logic                      int_dis_reg;
    logic                      ext_dis_reg;

    // ==========================================================
    // address decode
    wire logic hit_diag  = (reg_addr == `ASD_OFS_DIAG_SEL);
    wire logic hit_din   = (reg_addr == `ASD_OFS_DIN_LEVEL);
    wire logic hit_alert = (reg_addr == `ASD_OFS_ALERT);
    wire logic wr_diag   = reg_wr && hit_diag;
    wire logic wr_alert  = reg_wr && hit_alert;

    // ==========================================================
    // diagnostic slot selection
    wire logic [`ASD_SLOT_W-1:0] slot0_source_code =
        diag_sel_reg[`ASD_SLOT0_LSB +: `ASD_SLOT_W];
    wire logic [`ASD_SLOT_W-1:0] slot1_source_code =
        diag_sel_reg[`ASD_SLOT1_LSB +: `ASD_SLOT_W];
    asdsel_pkg::asdsel_route_t slot0_dec;
    asdsel_pkg::asdsel_route_t slot1_dec;

    asdsel_diag_route #(.SOURCING(1'b0)) u_slot0 (
        .code  (slot0_source_code),
        .route (slot0_dec)
    );

    asdsel_diag_route #(.SOURCING(1'b1)) u_slot1 (
        .code  (slot1_source_code),
        .route (slot1_dec)
    );

    // ==========================================================
    // digital input level
    logic din_debounced;

    asdsel_debounce #(.CNT_W(DEB_W)) u_deb (
        .sys_clk        (sys_clk),
        .srst           (srst),
        .ce             (ce),
        .comp_async     (comp_async),
        .debounce_limit (debounce_limit),
        .level          (din_debounced)
    );

    // ==========================================================
    // alert set sources
    logic [`ASD_DATA_W-1:0] set_vec;
    always_comb begin
        set_vec = '0;
        set_vec[`ASD_BIT_AN_OPEN]    = evt.analog_open;          // RULE_08
        set_vec[`ASD_BIT_AN_SHORT]   = evt.analog_short;         // RULE_09
        set_vec[`ASD_BIT_INT_TMO]    = evt.int_timeout;          // RULE_10
        set_vec[`ASD_BIT_EXT_TMO]    = evt.ext_timeout;          // RULE_10
        // shorts during the tolerance window are expected inrush
        set_vec[`ASD_BIT_INT_SHORT]  =
            evt.int_short && !short_tolerance_period;            // RULE_11
        set_vec[`ASD_BIT_EXT_SHORT]  =
            evt.ext_short && !short_tolerance_period;            // RULE_11
        set_vec[`ASD_BIT_THERMAL]    = evt.thermal_trip;         // RULE_12
        set_vec[`ASD_BIT_DI_OPEN]    = evt.di_open;              // RULE_13
        set_vec[`ASD_BIT_DI_SHORT]   = evt.di_short;             // RULE_13
        set_vec[`ASD_BIT_CONV_ERR]   = evt.conv_err;             // RULE_14
        set_vec[`ASD_BIT_OVER_TEMP]  = evt.over_temp;            // RULE_15
        set_vec[`ASD_BIT_POWER_LINK] = evt.link_busy || evt.link_ack; // RULE_16
        set_vec[`ASD_BIT_SERIAL]     = evt.serial_err;           // RULE_17
        set_vec[`ASD_BIT_RESET]      = evt.reset_evt;            // RULE_19
    end

    // ==========================================================
    // flag update: only ones in writable positions clear
    wire logic [`ASD_DATA_W-1:0] clr_vec =
        wr_alert ? (reg_wdata & `ASD_ALERT_W1C_MASK) : '0;       // RULE_20
    wire logic supply_any = |(supply_status & ~supply_mask);     // RULE_18
    logic [`ASD_DATA_W-1:0] flags_next;
    always_comb begin
        flags_next = ((flags_reg & ~clr_vec) | set_vec)
                     & `ASD_ALERT_W1C_MASK;                      // RULE_07 RULE_21
        flags_next[`ASD_BIT_SUPPLY] = supply_any;                // RULE_18
    end

    // ==========================================================
    // read mux; unmapped offsets read zero
    logic [`ASD_DATA_W-1:0] din_word;
    always_comb begin
        din_word    = `ASD_RST_DIN_LEVEL;
        din_word[0] = din_level_reg;                             // RULE_05
    end
    wire logic [`ASD_DATA_W-1:0] rd_mux =
        hit_diag  ? diag_sel_reg :
        hit_din   ? din_word :
        hit_alert ? flags_reg : '0;

    // ==========================================================
    // registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            diag_sel_reg  <= `ASD_RST_DIAG_SEL;
            flags_reg     <= `ASD_RST_ALERT;                     // RULE_19
            din_level_reg <= 1'b0;                               // RULE_05
            rdata_reg     <= '0;
            slot0_reg     <= '0;
            slot1_reg     <= '0;
            int_dis_reg   <= 1'b0;
            ext_dis_reg   <= 1'b0;
        end else if (ce) begin
            if (wr_diag) begin
                diag_sel_reg <= reg_wdata;
            end
            flags_reg     <= flags_next;
            din_level_reg <= din_debounced;                      // RULE_06
            if (reg_rd) begin
                rdata_reg <= rd_mux;
            end
            slot0_reg     <= slot0_dec;                          // RULE_03
            slot1_reg     <= slot1_dec;                          // RULE_04
            // output stays off until software clears the timeout
            int_dis_reg   <= flags_next[`ASD_BIT_INT_TMO];       // RULE_10
            ext_dis_reg   <= flags_next[`ASD_BIT_EXT_TMO];       // RULE_10
        end
    end

    assign reg_rdata          = rdata_reg;
    assign slot0_route        = slot0_reg;
    assign slot1_route        = slot1_reg;
    assign int_output_disable = int_dis_reg;
    assign ext_output_disable = ext_dis_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_reset_release;
        $fell(srst);
    endsequence

    a_reset_value: assert property (
        s_reset_release |-> flags_reg == `ASD_RST_ALERT
                            && din_level_reg == 1'b0)            // RULE_19
        else $error("alert register reset value wrong");

    a_clear_works: assert property (
        (ce && wr_alert && reg_wdata[`ASD_BIT_DI_OPEN]
         && !evt.di_open) |=> !flags_reg[`ASD_BIT_DI_OPEN])      // RULE_07
        else $error("write one did not clear flag");

    a_set_wins: assert property (
        (ce && wr_alert && reg_wdata[`ASD_BIT_CONV_ERR]
         && evt.conv_err) |=> flags_reg[`ASD_BIT_CONV_ERR])      // RULE_21
        else $error("clear beat a set in the same cycle");

    a_flag_latched: assert property (
        (ce && flags_reg[`ASD_BIT_AN_OPEN] && !wr_alert)
        |=> flags_reg[`ASD_BIT_AN_OPEN])                         // RULE_07
        else $error("latched flag dropped without clear");

    a_zero_no_clear: assert property (
        (ce && wr_alert && !reg_wdata[`ASD_BIT_RESET]
         && flags_reg[`ASD_BIT_RESET])
        |=> flags_reg[`ASD_BIT_RESET])                           // RULE_20
        else $error("writing zero cleared a flag");

    a_tol_gate: assert property (
        (ce && short_tolerance_period && !flags_reg[`ASD_BIT_INT_SHORT]
         && !wr_alert) |=> !flags_reg[`ASD_BIT_INT_SHORT])       // RULE_11
        else $error("short flagged inside tolerance window");

    a_timeout_off: assert property (
        (ce && evt.ext_timeout) |=> flags_reg[`ASD_BIT_EXT_TMO]
                                    && ext_output_disable)       // RULE_10
        else $error("external timeout did not disable output");

    a_supply_follow: assert property (
        ce |=> flags_reg[`ASD_BIT_SUPPLY] == $past(supply_any))  // RULE_18
        else $error("supply bit does not track unmasked alerts");

    a_serial_err: assert property (
        (ce && evt.serial_err) |=> flags_reg[`ASD_BIT_SERIAL])   // RULE_17
        else $error("serial error not latched");

    a_slot0_sink: assert property (
        (ce && slot0_source_code == `ASD_CODE_CURRENT)
        |=> slot0_route.current_sink && !slot0_route.current_source
            && slot0_route.voltage_sel == '0)                    // RULE_03
        else $error("slot 0 code 15 not routed to sink current");

    a_slot1_gnd: assert property (
        (ce && slot1_source_code == `ASD_CODE_GND_ALT)
        |=> slot1_route.voltage_sel[`ASD_SRC_GND])               // RULE_02
        else $error("slot 1 code 14 not routed to ground");

    a_reserved_zero: assert property (
        flags_reg[15] == 1'b0 && din_word[15:1] == '0)           // RULE_05
        else $error("reserved bits read nonzero");

endmodule : asdsel_top

/* tb/asdsel_host_model.sv */
// host model that drives the register port of the alert bank
`include "asdsel_defs.svh"
module asdsel_host_model (
    input  wire logic                   sys_clk,   // clock
    output logic      [`ASD_ADDR_W-1:0] reg_addr,  // register offset
    output logic                        reg_wr,    // write strobe
    output logic                        reg_rd,    // read strobe
    output logic      [`ASD_DATA_W-1:0] reg_wdata, // write data
    input  wire logic [`ASD_DATA_W-1:0] reg_rdata  // read data
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // idle bus
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 16'h0000;
    end

    // ==========================================================
    // register cycles; released lines show the inverse, not stale data
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        // read data stands until the next read, so take it on an edge
        @(posedge sys_clk);
        d = reg_rdata;
    endtask : read_reg

    // callers clear a flag once its condition has gone; test_supply also writes the supply bit while it is active
    task automatic clear_flags(input logic [15:0] m);
        write_reg(`ASD_OFS_ALERT, m);
    endtask : clear_flags
endmodule : asdsel_host_model

/* tb/tb.sv */
// self-checking bench of the alert status and diagnostic select bank
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                      sys_clk;
    logic                      srst;
    logic                      ce;
    logic [7:0]                reg_addr;
    logic                      reg_wr;
    logic                      reg_rd;
    logic [15:0]               reg_wdata;
    logic [15:0]               reg_rdata;
    asdsel_pkg::asdsel_evt_t   evt;
    logic                      short_tolerance_period;
    logic [7:0]                supply_status;
    logic [7:0]                supply_mask;
    logic                      comp_async;
    logic [15:0]               debounce_limit;
    asdsel_pkg::asdsel_route_t slot0_route;
    asdsel_pkg::asdsel_route_t slot1_route;
    logic                      int_output_disable;
    logic                      ext_output_disable;
    int                        mismatches;
    int                        checks;
    logic [15:0]               rd;

    asdsel_top #(.SUP_W(8), .DEB_W(16)) asdsel_top_inst (
        .sys_clk(sys_clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .evt(evt),
        .short_tolerance_period(short_tolerance_period),
        .supply_status(supply_status), .supply_mask(supply_mask),
        .comp_async(comp_async), .debounce_limit(debounce_limit),
        .slot0_route(slot0_route), .slot1_route(slot1_route),
        .int_output_disable(int_output_disable),
        .ext_output_disable(ext_output_disable));

    asdsel_host_model asdsel_host_model_inst (
        .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // ==========================================================
    // clock, reporting and helpers
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        asdsel_host_model_inst.read_reg(a, rd);
        check(rd, exp);
    endtask : rdchk

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : idle

    task automatic pulse(input logic [14:0] v);
        @(posedge sys_clk);
        evt <= asdsel_pkg::asdsel_evt_t'(v);
        @(posedge sys_clk);
        evt <= '0;
    endtask : pulse

    // voltage_sel index c sits at bit c+2 of the route word
    function automatic logic [15:0] route_exp(input logic [3:0] c,
                                              input logic src);
        if (c == 4'hF) return src ? 16'h0001 : 16'h0002;
        if (c == 4'hE) return 16'h0004;
        return 16'(16'h0004 << c);
    endfunction : route_exp

    // link faults share bit 3, serial error sits at bit 2
    function automatic int flag_of(input int i);
        if (i == 1) return 2;
        if (i == 2) return 3;
        return i;
    endfunction : flag_of

    // ==========================================================
    // scenarios
    task automatic test_reset();
        rdchk(8'h41, 16'h0001);
        rdchk(8'h40, 16'h0000);
        rdchk(8'h3C, 16'h0000);
        asdsel_host_model_inst.write_reg(8'h41, 16'h0000);
        rdchk(8'h41, 16'h0001);
        asdsel_host_model_inst.clear_flags(16'h0001);
        rdchk(8'h41, 16'h0000);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_routes();
        for (int c = 0; c < 16; c++) begin
            asdsel_host_model_inst.write_reg(8'h3C, {8'h00, 4'(c), 4'(c)});
            rdchk(8'h3C, {8'h00, 4'(c), 4'(c)});
            check(slot0_route, route_exp(4'(c), 1'b0));
            check(slot1_route, route_exp(4'(c), 1'b1));
        end
        $display("test_routes done");
    endtask : test_routes

    task automatic test_events();
        logic [15:0] e;
        for (int i = 0; i < 15; i++) begin
            e = 16'(16'h0001 << flag_of(i));
            pulse(15'(15'h0001 << i));
            rdchk(8'h41, e);
            idle(3);
            rdchk(8'h41, e);
            if (i == 12) check({15'h0000, int_output_disable}, 16'h0001);
            if (i == 11) check({15'h0000, ext_output_disable}, 16'h0001);
            asdsel_host_model_inst.write_reg(8'h41, ~e);
            rdchk(8'h41, e);
            asdsel_host_model_inst.clear_flags(e);
            rdchk(8'h41, 16'h0000);
            check({14'h0000, int_output_disable, ext_output_disable}, 16'h0000);
        end
        $display("test_events done");
    endtask : test_events

    task automatic test_tolerance();
        @(posedge sys_clk);
        short_tolerance_period <= 1'b1;
        pulse(15'h0600);
        rdchk(8'h41, 16'h0000);
        @(posedge sys_clk);
        short_tolerance_period <= 1'b0;
        $display("test_tolerance done");
    endtask : test_tolerance

    task automatic test_set_wins();
        @(posedge sys_clk);
        evt <= asdsel_pkg::asdsel_evt_t'(15'h0080);
        asdsel_host_model_inst.write_reg(8'h41, 16'h0080);
        evt <= '0;
        rdchk(8'h41, 16'h0080);
        asdsel_host_model_inst.clear_flags(16'h0080);
        rdchk(8'h41, 16'h0000);
        $display("test_set_wins done");
    endtask : test_set_wins

    task automatic test_supply();
        @(posedge sys_clk);
        supply_status <= 8'h01;
        idle(3);
        rdchk(8'h41, 16'h0002);
        asdsel_host_model_inst.clear_flags(16'h0002);
        rdchk(8'h41, 16'h0002);
        supply_mask <= 8'h01;
        idle(3);
        rdchk(8'h41, 16'h0000);
        supply_status <= 8'h80;
        idle(3);
        rdchk(8'h41, 16'h0002);
        supply_status <= 8'h00;
        idle(3);
        rdchk(8'h41, 16'h0000);
        $display("test_supply done");
    endtask : test_supply

    task automatic test_level();
        @(posedge sys_clk);
        comp_async <= 1'b1;
        rdchk(8'h40, 16'h0000);
        idle(12);
        rdchk(8'h40, 16'h0001);
        asdsel_host_model_inst.write_reg(8'h40, 16'h0000);
        rdchk(8'h40, 16'h0001);
        asdsel_host_model_inst.write_reg(8'h77, 16'hFFFF);
        rdchk(8'h77, 16'h0000);
        rdchk(8'h3C, 16'h00FF);
        $display("test_level done");
    endtask : test_level

    task automatic test_freeze();
        @(posedge sys_clk);
        ce <= 1'b0;
        pulse(15'h0010);
        @(posedge sys_clk);
        ce <= 1'b1;
        rdchk(8'h41, 16'h0000);
        $display("test_freeze done");
    endtask : test_freeze

    // ==========================================================
    // main sequence and hang guard
    initial begin
        mismatches = 0;
        checks = 0;
        srst = 1'b1;
        ce = 1'b1;
        evt = '0;
        short_tolerance_period = 1'b0;
        supply_status = 8'h00;
        supply_mask = 8'h00;
        comp_async = 1'b0;
        debounce_limit = 16'h0003;
        idle(16);
        srst <= 1'b0;
        test_reset();
        test_routes();
        test_events();
        test_tolerance();
        test_set_wins();
        test_supply();
        test_level();
        test_freeze();
        final_report();
    end

    initial begin
        idle(20000);
        mismatches++;
        final_report();
    end
endmodule : tb
